// File: core/eab_pkg.sv
// package for the group-5 acknowledge- or wait-terminated external access block
// assumes one system clock at 20 MHz drives every counter
package eab_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int          CLK_PERIOD_NS    = 50;
    localparam int          TIMEOUT_CYC      = 1022;  // bus time-out in clocks
    localparam int          ACK_WAIT_MAX_CYC = 1019;  // peripheral ack bound
    localparam int          WAIT_MAX_CYC     = 1020;  // peripheral wait bound
    localparam int          CS_MIN_CYC       = 3;     // least chip select width
    localparam int          ACK_RW_LAG_CYC   = 2;     // ack seen to rw negate
    localparam int          WAIT_RW_LAG_CYC  = 1;     // wait seen to rw negate
    localparam int          WAIT_OE_LAG_CYC  = 2;     // wait seen to oe negate
    localparam int          ACK_TAIL_CYC     = 2;     // rw/oe negate to cs negate, ack
    localparam int          WAIT_TAIL_CYC    = 3;     // rw negate to cs negate, wait writes
    localparam int          DMA_GAP_CYC      = 1;     // idle between accesses
    // ****************************************
    // field widths and reset values
    // ****************************************
    localparam int          ADDR_W           = 24;
    localparam int          DATA_W           = 16;
    localparam int          BE_W             = 2;
    localparam int          DLY_W            = 4;
    localparam int          CNT_W            = 11;
    localparam logic [10:0] TIMEOUT_CNT      = 11'h3fe;
    localparam logic [1:0]  BE_IDLE          = 2'h3;

    typedef enum logic [6:0] {
        EAB_IDLE  = 7'h01,
        EAB_SETUP = 7'h02,
        EAB_WAITT = 7'h04,
        EAB_LAG   = 7'h08,
        EAB_TAIL  = 7'h10,
        EAB_BEOFF = 7'h20,
        EAB_GAP   = 7'h40
    } eab_state_t;
endpackage

// File: core/eab_sync_if.sv
// carrier between the top and the input synchroniser
// assumes both ends share i_clk
`timescale 1ns/1ps
interface eab_sync_if;
    logic raw_ack_n;
    logic raw_wait_n;
    logic ack_low;
    logic wait_low;
    modport src (output raw_ack_n, output raw_wait_n, input ack_low, input wait_low);
    modport snk (input raw_ack_n, input raw_wait_n, output ack_low, output wait_low);
endinterface

// File: core/eab_sync.sv
// three-stage synchroniser for the acknowledge and wait pins
// assumes pins are asynchronous to i_clk; a change counts when stages two and three agree
`timescale 1ns/1ps
module eab_sync
    import eab_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // pin side and clean side
    eab_sync_if.snk   sif
);
    logic [2:0] ack_r,  ack_nxt;
    logic [2:0] wt_r,   wt_nxt;
    logic       ackq_r, ackq_nxt;
    logic       wtq_r,  wtq_nxt;

    // shift and agree-filter; low pin means asserted
    always_comb begin
        ack_nxt  = {ack_r[1:0], sif.raw_ack_n};
        wt_nxt   = {wt_r[1:0], sif.raw_wait_n};
        ackq_nxt = (ack_r[1] == ack_r[2]) ? ~ack_r[2] : ackq_r;
        wtq_nxt  = (wt_r[1] == wt_r[2]) ? ~wt_r[2] : wtq_r;
    end

    // registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_r  <= 3'h7;
            wt_r   <= 3'h7;
            ackq_r <= 1'b0;
            wtq_r  <= 1'b0;
        end else begin
            ack_r  <= ack_nxt;
            wt_r   <= wt_nxt;
            ackq_r <= ackq_nxt;
            wtq_r  <= wtq_nxt;
        end
    end

    assign sif.ack_low  = ackq_r;
    assign sif.wait_low = wtq_r;
endmodule

// File: core/eab_core.sv
// group-5 external access engine ending cycles by acknowledge, wait or internal count
// assumes one request strobe from the host side; pins ack and wait are asynchronous
`timescale 1ns/1ps
module eab_core
    import eab_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // access request
    input  wire logic              i_req,
    input  wire logic              i_write,
    input  wire logic              i_grp5,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [BE_W-1:0]   i_be,
    input  wire logic              i_dma_en,
    // group-5 control setting
    input  wire logic              i_ack_mode_select,
    input  wire logic              i_ext_term_en,
    input  wire logic [5:0]        i_wait_state_count,
    input  wire logic [DLY_W-1:0]  i_oe_assert_delay,
    input  wire logic [DLY_W-1:0]  i_cs_assert_delay,
    input  wire logic [DLY_W-1:0]  i_we_assert_delay,
    input  wire logic              i_byte_en_control,
    // pins from peripheral
    input  wire logic              i_ext_data_ack_n,
    input  wire logic              i_ext_wait_n,
    input  wire logic [DATA_W-1:0] i_rdata_pin,
    // pins to peripheral
    output logic                   o_chip_select_grp5_n,
    output logic                   o_oe_n,
    output logic                   o_rw_n,
    output logic [BE_W-1:0]        o_byte_enable_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_data_out,
    output logic                   o_data_oe,
    // status to host
    output logic                   o_busy,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_bus_error
);
    // ****************************************
    // pin synchroniser
    // ****************************************
    eab_sync_if sif();
    assign sif.raw_ack_n  = i_ext_data_ack_n;
    assign sif.raw_wait_n = i_ext_wait_n;
    eab_sync u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .sif   (sif)
    );

    // ****************************************
    // state and pin registers
    // ****************************************
    eab_state_t        st_r,   st_nxt;
    logic [CNT_W-1:0]  cnt_r,  cnt_nxt;   // clocks since chip select asserted
    logic [CNT_W-1:0]  lag_r,  lag_nxt;   // generic phase counter
    logic              wr_r,   wr_nxt;
    logic              ack_m_r, ack_m_nxt; // latched mode: 1 = acknowledge
    logic              int_r,  int_nxt;    // internal wait states
    logic              dma_r,  dma_nxt;
    logic              cs_r,   cs_nxt;
    logic              oe_r,   oe_nxt;
    logic              rw_r,   rw_nxt;
    logic [BE_W-1:0]   be_r,   be_nxt;
    logic [BE_W-1:0]   bem_r,  bem_nxt;
    logic [ADDR_W-1:0] ad_r,   ad_nxt;
    logic [DATA_W-1:0] dq_r,   dq_nxt;
    logic              doe_r,  doe_nxt;
    logic              done_r, done_nxt;
    logic [DATA_W-1:0] rd_r,   rd_nxt;
    logic              err_r,  err_nxt;
    logic              term;
    logic              cs_on;
    logic              busy_r, busy_nxt;
    // termination source chosen by mode; internal count needs no pin
    always_comb begin
        term = ack_m_r ? sif.ack_low : sif.wait_low;
        if (int_r) begin
            term = (cnt_r >= CNT_W'(i_wait_state_count)) && (cnt_r >= CNT_W'(CS_MIN_CYC));
        end
    end
    // next-state and pin computation
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        lag_nxt   = lag_r;
        wr_nxt    = wr_r;
        ack_m_nxt = ack_m_r;
        int_nxt   = int_r;
        dma_nxt   = dma_r;
        cs_nxt    = cs_r;
        oe_nxt    = oe_r;
        rw_nxt    = rw_r;
        be_nxt    = be_r;
        bem_nxt   = bem_r;
        ad_nxt    = ad_r;
        dq_nxt    = dq_r;
        doe_nxt   = doe_r;
        done_nxt  = 1'b0;
        rd_nxt    = rd_r;
        err_nxt   = 1'b0;
        cs_on     = 1'b0;
        unique case (st_r)
            EAB_IDLE: begin
                if (i_req && i_grp5) begin
                    st_nxt    = EAB_SETUP;
                    wr_nxt    = i_write;
                    ack_m_nxt = ~i_ack_mode_select;
                    int_nxt   = ~i_ext_term_en;
                    dma_nxt   = i_dma_en;
                    ad_nxt    = i_addr;
                    rw_nxt    = ~i_write;
                    dq_nxt    = i_wdata;
                    doe_nxt   = i_write;
                    bem_nxt   = i_be;
                    lag_nxt   = '0;
                    cnt_nxt   = '0;
                end
            end
            EAB_SETUP: begin
                // programmed delay before chip select: cs field for writes
                lag_nxt = lag_r + CNT_W'(1);
                if (!wr_r || lag_r >= CNT_W'(i_cs_assert_delay)) begin
                    cs_on   = 1'b1;
                    st_nxt  = EAB_WAITT;
                    lag_nxt = '0;
                end
            end
            EAB_WAITT: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                // output enable and read byte enables after oe delay
                if (!wr_r && cnt_r >= CNT_W'(i_oe_assert_delay)) begin
                    oe_nxt = 1'b0;
                    if (!i_byte_en_control) begin
                        be_nxt = ~bem_r;
                    end
                end
                // write byte enables after we delay
                if (wr_r && cnt_r >= CNT_W'(i_we_assert_delay)) begin
                    be_nxt = ~bem_r;
                end
                // bus time-out only for externally acknowledged cycles
                err_nxt = ack_m_r && !int_r && (cnt_r >= TIMEOUT_CNT);
                if (err_nxt || term) begin
                    st_nxt  = EAB_LAG;
                    lag_nxt = '0;
                end
            end
            EAB_LAG: begin
                // delay from termination seen to rw or oe negate
                cnt_nxt = cnt_r + CNT_W'(1);
                lag_nxt = lag_r + CNT_W'(1);
                if (lag_r + CNT_W'(1) >= ((wr_r && !ack_m_r) ? CNT_W'(WAIT_RW_LAG_CYC) :
                                          CNT_W'(ACK_RW_LAG_CYC))) begin
                    rw_nxt  = 1'b1;
                    oe_nxt  = 1'b1;
                    be_nxt  = wr_r ? be_r : BE_IDLE;
                    st_nxt  = EAB_TAIL;
                    lag_nxt = '0;
                    if (!wr_r) begin
                        rd_nxt = i_rdata_pin;
                    end
                end
            end
            EAB_TAIL: begin
                // rw/oe lead cs negate; wait reads take the short tail
                cnt_nxt = cnt_r + CNT_W'(1);
                lag_nxt = lag_r + CNT_W'(1);
                if (lag_r + CNT_W'(1) >= ((ack_m_r || !wr_r) ? CNT_W'(ACK_TAIL_CYC) :
                                          CNT_W'(WAIT_TAIL_CYC)) &&
                    cnt_r + CNT_W'(1) >= CNT_W'(CS_MIN_CYC)) begin
                    cs_nxt  = 1'b1;
                    doe_nxt = 1'b0;
                    st_nxt  = wr_r ? EAB_BEOFF : EAB_GAP;
                end
            end
            EAB_BEOFF: begin
                be_nxt = BE_IDLE;
                st_nxt = EAB_GAP;
            end
            EAB_GAP: begin
                done_nxt = 1'b1;
                st_nxt   = EAB_IDLE;  // at least one idle clock before next cs
            end
            default: begin
                st_nxt = EAB_IDLE;
                cs_nxt = 1'b1;
            end
        endcase
        if (cs_on) begin
            cs_nxt = 1'b0;
        end
        busy_nxt = (st_nxt != EAB_IDLE);
    end
    // registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r    <= EAB_IDLE;
            cnt_r   <= '0;
            lag_r   <= '0;
            wr_r    <= 1'b0;
            ack_m_r <= 1'b1;
            int_r   <= 1'b0;
            dma_r   <= 1'b0;
            cs_r    <= 1'b1;
            oe_r    <= 1'b1;
            rw_r    <= 1'b1;
            be_r    <= BE_IDLE;
            bem_r   <= '0;
            ad_r    <= '0;
            dq_r    <= '0;
            doe_r   <= 1'b0;
            done_r  <= 1'b0;
            rd_r    <= '0;
            err_r   <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            lag_r   <= lag_nxt;
            wr_r    <= wr_nxt;
            ack_m_r <= ack_m_nxt;
            int_r   <= int_nxt;
            dma_r   <= dma_nxt;
            cs_r    <= cs_nxt;
            oe_r    <= oe_nxt;
            rw_r    <= rw_nxt;
            be_r    <= be_nxt;
            bem_r   <= bem_nxt;
            ad_r    <= ad_nxt;
            dq_r    <= dq_nxt;
            doe_r   <= doe_nxt;
            done_r  <= done_nxt;
            rd_r    <= rd_nxt;
            err_r   <= err_nxt;
            busy_r  <= busy_nxt;
        end
    end
    // outputs straight from flip-flops
    assign o_chip_select_grp5_n = cs_r;
    assign o_oe_n               = oe_r;
    assign o_rw_n               = rw_r;
    assign o_byte_enable_n      = be_r;
    assign o_addr               = ad_r;
    assign o_data_out           = dq_r;
    assign o_data_oe            = doe_r;
    assign o_busy               = busy_r;
    assign o_done               = done_r;
    assign o_rdata              = rd_r;
    assign o_bus_error          = err_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_cs_width;
        @(posedge i_clk) disable iff (i_rst)
        $fell(cs_r) |-> !cs_r [*3];
    endproperty
    a_cs_width: assert property (p_cs_width) else $error("cs too short");
    property p_rw_before_cs;
        @(posedge i_clk) disable iff (i_rst)
        $rose(cs_r) && wr_r |-> $past(rw_r, 1) && $past(rw_r, 2);
    endproperty
    a_rw_before_cs: assert property (p_rw_before_cs) else $error("rw not ahead of cs");
    property p_ack_rw;
        @(posedge i_clk) disable iff (i_rst)
        (st_r == EAB_WAITT) && term && ack_m_r && wr_r && !int_r |-> ##3 $rose(rw_r);
    endproperty
    a_ack_rw: assert property (p_ack_rw) else $error("ack rw lag wrong");
    property p_wait_rw;
        @(posedge i_clk) disable iff (i_rst)
        (st_r == EAB_WAITT) && term && !ack_m_r && wr_r && !err_nxt |-> ##2 $rose(rw_r);
    endproperty
    a_wait_rw: assert property (p_wait_rw) else $error("wait rw lag wrong");
    property p_wait_oe;
        @(posedge i_clk) disable iff (i_rst)
        (st_r == EAB_WAITT) && term && !ack_m_r && !wr_r && !oe_r |-> ##3 $rose(oe_r);
    endproperty
    a_wait_oe: assert property (p_wait_oe) else $error("wait oe lag wrong");
    property p_data_hold;
        @(posedge i_clk) disable iff (i_rst)
        $rose(rw_r) && wr_r |-> doe_r [*2];
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data dropped early");
    property p_be_after_cs;
        @(posedge i_clk) disable iff (i_rst)
        $rose(cs_r) && wr_r |-> ##1 (be_r == BE_IDLE);
    endproperty
    a_be_after_cs: assert property (p_be_after_cs) else $error("be not negated");
    property p_read_be;
        @(posedge i_clk) disable iff (i_rst)
        !wr_r && i_byte_en_control && $stable(i_byte_en_control) && (st_r == EAB_WAITT)
            |-> $stable(be_r);
    endproperty
    a_read_be: assert property (p_read_be) else $error("read be with control set");
    property p_gap;
        @(posedge i_clk) disable iff (i_rst)
        $rose(cs_r) |-> ##1 cs_r;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle clock");
    property p_timeout;
        @(posedge i_clk) disable iff (i_rst)
        err_r |-> $past(cnt_r) == TIMEOUT_CNT;
    endproperty
    a_timeout: assert property (p_timeout) else $error("bus error at wrong count");
    c_write: cover property (@(posedge i_clk) $rose(cs_r) && wr_r);
    c_read:  cover property (@(posedge i_clk) $rose(cs_r) && !wr_r);
    c_err:   cover property (@(posedge i_clk) err_r);
endmodule

// File: testbench/eab_periph.sv
// far-side peripheral model ending group-5 cycles by acknowledge or wait
// assumes pins are sampled on i_clk; released lines float up to the pull-up level
`timescale 1ns/1ps
module eab_periph
    import eab_pkg::*;
(
    // pins from the block
    input  wire logic              i_clk,
    input  wire logic              i_cs_n,
    input  wire logic              i_oe_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    // bench control
    input  wire logic              i_use_wait,
    input  wire logic              i_mute,
    input  wire logic [9:0]        i_delay,
    // pins to the block
    output logic                   o_ack_n,
    output logic                   o_wait_n,
    output logic [DATA_W-1:0]      o_rdata
);
    int cnt;
    int held;
    initial begin
        o_ack_n  = 1'b1;
        o_wait_n = 1'b1;
        o_rdata  = 16'h0000;
    end
    // answer after a chosen delay; ack is a short pulse, wait stays low until cs rises
    always @(posedge i_clk) begin
        if (i_cs_n !== 1'b0) begin
            cnt      <= 0;
            held     <= 0;
            o_ack_n  <= 1'b1;
            o_wait_n <= 1'b1;
        end else begin
            cnt <= cnt + 1;
            if (!i_mute && cnt == int'(i_delay)) begin
                if (i_use_wait) o_wait_n <= 1'b0;
                else o_ack_n <= 1'b0;
            end
            if (o_ack_n == 1'b0) begin
                held <= held + 1;
                if (held == 2) o_ack_n <= 1'b1; // pulse lasts at most three clocks
            end
        end
        // data bus toggles when not read-enabled so a late capture shows up
        if (i_oe_n === 1'b0) o_rdata <= i_addr[DATA_W-1:0] ^ 16'h5a3c;
        else o_rdata <= ~o_rdata;
    end
endmodule

// File: testbench/eab_core_tb.sv
// self-checking bench for the group-5 external access engine
// assumes the peripheral model answers on the pins; one 20 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module eab_core_tb
    import eab_pkg::*;
;
    logic i_clk, i_rst, i_req, i_write, i_grp5, i_dma_en, i_ack_mode_select, i_ext_term_en;
    logic [5:0] i_wait_state_count;
    logic [DLY_W-1:0] i_oe_assert_delay, i_cs_assert_delay, i_we_assert_delay;
    logic i_byte_en_control, ack_n, wait_n, cs_n, oe_n, rw_n, doe, busy, done, berr;
    logic [ADDR_W-1:0] i_addr, addr, acw, acr;
    logic [DATA_W-1:0] i_wdata, rpin, dout, rdata, dcap;
    logic [BE_W-1:0] i_be, be_n;
    logic p_wait, p_mute, pcs, prw, poe, pdoe, ppin, be_low;
    logic [1:0] pbe;
    logic [9:0] p_dly;
    int seed, n_mismatch, num_checks, cyc, lead, oeo;
    int t_csf, t_csr, t_rwf, t_rwr, t_oef, t_oer, t_ber, t_doef, t_pinf, t_err;
    logic [DATA_W-1:0] exp_q[$];

    eab_core eab_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_write(i_write),
        .i_grp5(i_grp5), .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be), .i_dma_en(i_dma_en),
        .i_ack_mode_select(i_ack_mode_select), .i_ext_term_en(i_ext_term_en),
        .i_wait_state_count(i_wait_state_count), .i_oe_assert_delay(i_oe_assert_delay),
        .i_cs_assert_delay(i_cs_assert_delay), .i_we_assert_delay(i_we_assert_delay),
        .i_byte_en_control(i_byte_en_control), .i_ext_data_ack_n(ack_n), .i_ext_wait_n(wait_n),
        .i_rdata_pin(rpin), .o_chip_select_grp5_n(cs_n), .o_oe_n(oe_n), .o_rw_n(rw_n),
        .o_byte_enable_n(be_n), .o_addr(addr), .o_data_out(dout), .o_data_oe(doe),
        .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_bus_error(berr));
    eab_periph eab_periph_inst (.i_clk(i_clk), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_addr(addr),
        .i_use_wait(p_wait), .i_mute(p_mute), .i_delay(p_dly), .o_ack_n(ack_n),
        .o_wait_n(wait_n), .o_rdata(rpin));

    // clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // edge monitor: records the cycle of cs, rw and oe edges, be and data-enable release and pin fall
    always @(posedge i_clk) begin
        cyc++;
        if (pcs === 1'b1 && cs_n === 1'b0) begin t_csf = cyc; acr = addr; end
        if (pcs === 1'b0 && cs_n === 1'b1) t_csr = cyc;
        if (prw === 1'b1 && rw_n === 1'b0) begin t_rwf = cyc; acw = addr; end
        if (prw === 1'b0 && rw_n === 1'b1) t_rwr = cyc;
        if (poe === 1'b1 && oe_n === 1'b0) t_oef = cyc;
        if (poe === 1'b0 && oe_n === 1'b1) t_oer = cyc;
        if (pbe !== 2'h3 && be_n === 2'h3) t_ber = cyc;
        if (pdoe === 1'b1 && doe === 1'b0) t_doef = cyc;
        if (ppin === 1'b1 && (p_wait ? wait_n : ack_n) === 1'b0) t_pinf = cyc;
        if (cyc == t_csf + 1) dcap = dout;
        if (be_n !== 2'h3) be_low = 1'b1;
        if (berr === 1'b1) t_err = cyc;
        {pcs, prw, poe, pbe, pdoe, ppin} = {cs_n, rw_n, oe_n, be_n, doe, p_wait ? wait_n : ack_n};
    end

    // ****************************************
    // one access and its checks
    // ****************************************
    task automatic access(input logic wr, wt, ext, bec, mute, input logic [3:0] cd, od,
                          input logic [5:0] wait_state_count, input int dly);
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d, ex;
        int n, prv, lag, tgt, mn;
        a = 24'($random(seed));
        d = 16'($random(seed));
        prv = t_csr;
        be_low = 1'b0;
        t_err = -1;
        @(posedge i_clk);
        {i_req, i_write, i_grp5, i_addr, i_wdata} <= {1'b1, wr, 1'b1, a, d};
        {i_ack_mode_select, i_ext_term_en, i_byte_en_control, i_wait_state_count} <=
            {wt, ext, bec, wait_state_count};
        {i_cs_assert_delay, i_we_assert_delay, i_oe_assert_delay} <= {cd, cd, od};
        {p_wait, p_mute, p_dly} <= {wt, mute, 10'(dly)};
        exp_q.push_back(a[DATA_W-1:0] ^ 16'h5a3c);
        @(posedge i_clk);
        i_req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1200) begin
            @(posedge i_clk);
            n++;
        end
        repeat (2) @(posedge i_clk);
        ex = exp_q.pop_front();
        mn = ext ? CS_MIN_CYC : ((wait_state_count > 3) ? int'(wait_state_count) : 3);
        `CHK("finished", 1'b1, n < 1200)
        `CHK("idle", 1'b0, busy)
        `CHK("cs width", 1'b1, t_csr - t_csf >= mn)
        `CHK("cs gap", 1'b1, t_csf - prv >= 1 + DMA_GAP_CYC)
        `CHK("bus error", (mute && ext && !wt), t_err >= 0)
        if (mute && ext && !wt) `CHK("timeout", 1'b1, t_err - t_csf inside {[1022:1026]})
        if (ext && !mute) begin
            tgt = wr ? (wt ? WAIT_RW_LAG_CYC : ACK_RW_LAG_CYC)
                     : (wt ? WAIT_OE_LAG_CYC : ACK_RW_LAG_CYC);
            lag = (wr ? t_rwr : t_oer) - t_pinf;
            `CHK("term lag", 1'b1, lag >= 3 + tgt && lag <= 5 + tgt)
            tgt = (wt && wr) ? WAIT_TAIL_CYC : ACK_TAIL_CYC;
            `CHK("tail", tgt, t_csr - (wr ? t_rwr : t_oer))
        end
        if (wr) begin
            lead = t_csf - t_rwf;
            `CHK("wdata", d, dcap)
            `CHK("be off", 1, t_ber - t_csr)
            `CHK("waddr", a, acw)
            `CHK("rw first", 1'b1, t_rwf <= t_csf)
            if (wt && ext) `CHK("data hold", 1'b1, t_doef - t_rwr >= 2)
        end else begin
            oeo = t_oef - t_csf;
            `CHK("read be", ~bec, be_low)
            `CHK("raddr", a, acr)
            if (!mute) `CHK("rdata", ex, rdata)
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int l0, o0, i;
        seed = 85898;
        {i_rst, i_req, i_write, i_grp5, i_dma_en, i_ack_mode_select, i_ext_term_en} = 7'h40;
        {i_addr, i_wdata, i_be, i_wait_state_count, i_byte_en_control} = '0;
        {i_oe_assert_delay, i_cs_assert_delay, i_we_assert_delay} = '0;
        {p_wait, p_mute, p_dly, t_csr, t_err, cyc} = '0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        i_dma_en <= 1'b1;
        i_be <= 2'h3;
        access(1, 0, 1, 0, 0, 0, 0, 6'h03, 4);
        l0 = lead;
        access(1, 0, 1, 0, 0, 4'h2, 0, 6'h03, 0);
        `CHK("cs delay", 2, lead - l0)
        access(0, 0, 1, 0, 0, 0, 0, 6'h03, 7);
        o0 = oeo;
        access(0, 0, 1, 1, 0, 0, 4'h3, 6'h03, 1);
        `CHK("oe delay", 3, oeo - o0)
        access(1, 1, 1, 0, 0, 0, 0, 6'h03, 5);
        access(0, 1, 1, 0, 0, 0, 0, 6'h03, 0);
        access(0, 0, 0, 0, 1, 0, 0, 6'h02, 0);
        access(1, 1, 0, 0, 1, 0, 0, 6'h08, 0);
        access(1, 0, 1, 0, 1, 0, 0, 6'h03, 0);
        // a request to another group is dropped
        @(posedge i_clk);
        {i_req, i_grp5} <= 2'h2;
        @(posedge i_clk);
        i_req <= 1'b0;
        repeat (3) @(posedge i_clk);
        `CHK("other grp", 2'h1, {busy, cs_n})
        for (i = 0; i < 4; i++)
            access(1'($random(seed)), 1'($random(seed)), 1, 0, 0, 0, 0, 6'h03,
                   {$random(seed)} % 16);
        final_report;
    end

    // watchdog
    initial begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        final_report;
    end
endmodule
